/* File: rtl/fifo_pkg.sv */
package fifo_pkg;
    localparam int WORD_W = 4;
    localparam int STACK_DEPTH = 14;
    localparam int FIFO_WORDS = 16;
    localparam logic [4:0] IN_INIT = 5'h10;
    localparam int FULL_BIT = 0;
    localparam int SER_BITS = 4;
    localparam int LINK_DIV = 4;
endpackage

/* File: rtl/fifo_link_if.sv */
`timescale 1ns/1ps
interface fifo_link_if;
    logic parallel_load;
    logic serial_in_clock_n;
    logic serial_in_enable_n;
    logic transfer_to_stack_n;
    logic transfer_out_parallel;
    logic transfer_out_serial_n;
    logic serial_out_enable_n;
    logic master_reset_n;
    logic serial_out_clock_n;
    logic output_enable_n;
    logic serial_data_in;
    logic [3:0] parallel_data_in;
    logic input_full_n;
    logic output_empty_n;
    logic [3:0] parallel_data_out;
    logic [3:0] parallel_data_out_oe_n;
    logic serial_data_out;
    logic serial_data_out_oe_n;
    modport device (
        input parallel_load, serial_in_clock_n, serial_in_enable_n, transfer_to_stack_n,
        input transfer_out_parallel, transfer_out_serial_n, serial_out_enable_n, master_reset_n,
        input serial_out_clock_n, output_enable_n, serial_data_in, parallel_data_in,
        output input_full_n, output_empty_n, parallel_data_out, parallel_data_out_oe_n,
        output serial_data_out, serial_data_out_oe_n
    );
    modport controller (
        output parallel_load, serial_in_clock_n, serial_in_enable_n, transfer_to_stack_n,
        output transfer_out_parallel, transfer_out_serial_n, serial_out_enable_n, master_reset_n,
        output serial_out_clock_n, output_enable_n, serial_data_in, parallel_data_in,
        input input_full_n, output_empty_n, parallel_data_out, parallel_data_out_oe_n,
        input serial_data_out, serial_data_out_oe_n
    );
endinterface

/* File: rtl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule

/* File: rtl/fifo_device.sv */
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module fifo_device (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    fifo_link_if.device link
);
    import fifo_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam int NS = 11 + WORD_W;
    localparam logic [NS-1:0] SYNC_IDLE = {3'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0,
        {WORD_W{1'b0}}};
    logic [NS-1:0] raw_in;
    logic [NS-1:0] syn;
    assign raw_in = {link.parallel_load, link.serial_in_clock_n, link.serial_in_enable_n,
        link.transfer_to_stack_n, link.transfer_out_parallel, link.transfer_out_serial_n,
        link.serial_out_enable_n, link.master_reset_n, link.serial_out_clock_n,
        link.output_enable_n, link.serial_data_in, link.parallel_data_in};
    // reset values match the idle pin levels, soc_n and oe_n included; no false soc_n falling edge follows reset
    pin_sync #(.WIDTH(NS), .RESET_VAL(SYNC_IDLE)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async(raw_in),
        .o_sync(syn)
    );
    wire pl = syn[NS-1];
    wire sic_n = syn[NS-2];
    wire sie_n = syn[NS-3];
    wire tts_n = syn[NS-4];
    wire top = syn[NS-5];
    wire tos_n = syn[NS-6];
    wire mr_n = syn[NS-8];
    wire soc_n = syn[NS-9];
    wire oe_n = syn[NS-10];
    wire sdi = syn[NS-11];
    wire [WORD_W-1:0] pdi = syn[WORD_W-1:0];

    // ----------------------------------------------------------------
    // falling edge detect on the link clocks
    // ----------------------------------------------------------------
    function automatic logic fell(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction

    logic sic_d_reg;
    logic soc_d_reg;
    wire sic_fall = fell(sic_d_reg, sic_n);
    wire soc_fall = fell(soc_d_reg, soc_n);

    // ----------------------------------------------------------------
    // input register and master latch
    // ----------------------------------------------------------------
    logic [4:0] in_reg;
    logic req_init_reg;
    logic master_reg;
    logic [WORD_W-1:0] stack_mem [STACK_DEPTH];
    logic [STACK_DEPTH-1:0] valid_reg;
    wire in_full = in_reg[FULL_BIT];
    wire take_word = in_full & ~tts_n & ~valid_reg[0] & ~req_init_reg;
    wire do_init = req_init_reg & ~pl & master_reg;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            master_reg <= 1'b0;
            sic_d_reg <= 1'b0;
            soc_d_reg <= 1'b0;
        end else begin
            sic_d_reg <= sic_n;
            soc_d_reg <= soc_n;
            if (!mr_n && !sie_n) begin
                master_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // input register
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            in_reg <= IN_INIT;
            req_init_reg <= 1'b0;
        end else if (!mr_n || do_init) begin
            in_reg <= IN_INIT;
            req_init_reg <= 1'b0;
        end else begin
            if (take_word) begin
                req_init_reg <= 1'b1;
            end
            if (pl) begin
                in_reg <= {pdi[3], pdi[2], pdi[1], pdi[0], 1'b1};
            end else if (sic_fall && !sie_n && !in_full) begin
                in_reg <= {sdi, in_reg[4:1]};
            end
        end
    end

    // ----------------------------------------------------------------
    // fall-through stack
    // ----------------------------------------------------------------
    logic [3:0] out_reg;
    logic out_full_reg;
    logic out_taken_reg;
    logic [2:0] sh_cnt_reg;
    logic ser_mode_reg;
    wire bottom = valid_reg[STACK_DEPTH-1];
    wire load_out = bottom & top & ~out_taken_reg & ~out_full_reg & master_reg;

    wire [STACK_DEPTH-1:0] move_in;
    wire [STACK_DEPTH-1:0] move_out;
    assign move_in[0] = take_word;
    assign move_out[STACK_DEPTH-1] = load_out;

    // a word drops only while the location below is free
    generate
        for (genvar g = 0; g < STACK_DEPTH; g++) begin : g_loc
            if (g > 0) begin : g_fall
                assign move_in[g] = valid_reg[g-1] & ~valid_reg[g];
                assign move_out[g-1] = move_in[g];
            end
            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    valid_reg[g] <= 1'b0;
                end else if (!mr_n) begin
                    valid_reg[g] <= 1'b0;
                end else if (move_in[g]) begin
                    valid_reg[g] <= 1'b1;
                end else if (move_out[g]) begin
                    valid_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // stack data
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (move_in[0]) begin
            stack_mem[0] <= in_reg[4:1];
        end
        for (int i = 1; i < STACK_DEPTH; i++) begin
            if (move_in[i]) begin
                stack_mem[i] <= stack_mem[i-1];
            end
        end
    end

    // ----------------------------------------------------------------
    // output register
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_reg <= 4'h0;
            out_full_reg <= 1'b0;
            out_taken_reg <= 1'b0;
            sh_cnt_reg <= 3'h0;
            ser_mode_reg <= 1'b0;
        end else if (!mr_n) begin
            out_full_reg <= 1'b0;
            out_taken_reg <= 1'b0;
            sh_cnt_reg <= 3'h0;
            ser_mode_reg <= 1'b0;
        end else begin
            // level acting transfer out; the taken flag blocks a second load
            if (!top) begin
                out_taken_reg <= 1'b0;
                out_full_reg <= 1'b0;
            end
            if (load_out) begin
                out_reg <= stack_mem[STACK_DEPTH-1];
                out_full_reg <= 1'b1;
                out_taken_reg <= 1'b1;
                ser_mode_reg <= ~tos_n;
                sh_cnt_reg <= 3'h0;
            end else if (ser_mode_reg && out_full_reg && soc_fall) begin
                out_reg <= {1'b0, out_reg[3:1]};
                sh_cnt_reg <= sh_cnt_reg + 3'h1;
                if (sh_cnt_reg == 3'(SER_BITS - 1)) begin
                    out_full_reg <= 1'b0;
                    ser_mode_reg <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link.input_full_n <= 1'b1;
            link.output_empty_n <= 1'b0;
            link.parallel_data_out <= 4'h0;
            link.parallel_data_out_oe_n <= 4'hf;
            link.serial_data_out <= 1'b0;
            link.serial_data_out_oe_n <= 1'b1;
        end else begin
            link.input_full_n <= ~in_full;
            link.output_empty_n <= out_full_reg;
            link.parallel_data_out <= out_reg;
            link.parallel_data_out_oe_n <= {WORD_W{oe_n}};
            link.serial_data_out <= out_reg[0];
            link.serial_data_out_oe_n <= ~(ser_mode_reg & out_full_reg);
        end
    end
endmodule

/* File: rtl/fifo_controller.sv */
`timescale 1ns/1ps
module fifo_controller (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_write,
    input wire logic [3:0] i_wdata,
    input wire logic i_read,
    output logic o_in_full,
    output logic o_out_valid,
    output logic [3:0] o_rdata,
    fifo_link_if.controller link
);
    import fifo_pkg::*;

    // ----------------------------------------------------------------
    // flag sync and parallel handshake
    // ----------------------------------------------------------------
    logic [5:0] syn;
    pin_sync #(.WIDTH(6), .RESET_VAL(6'h20)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async({link.input_full_n, link.output_empty_n, link.parallel_data_out}),
        .o_sync(syn)
    );
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link.parallel_load <= 1'b0;
            link.serial_in_clock_n <= 1'b0;
            link.serial_in_enable_n <= 1'b0;
            link.transfer_to_stack_n <= 1'b1;
            link.transfer_out_parallel <= 1'b0;
            link.transfer_out_serial_n <= 1'b0;
            link.serial_out_enable_n <= 1'b0;
            link.master_reset_n <= 1'b0;
            link.serial_out_clock_n <= 1'b0;
            link.output_enable_n <= 1'b1;
            link.serial_data_in <= 1'b0;
            link.parallel_data_in <= 4'h0;
            o_in_full <= 1'b0;
            o_out_valid <= 1'b0;
            o_rdata <= 4'h0;
        end else begin
            link.master_reset_n <= 1'b1;
            link.parallel_load <= i_write & syn[5];
            link.parallel_data_in <= i_wdata;
            link.transfer_to_stack_n <= syn[5];
            link.transfer_out_parallel <= i_read & ~syn[4];
            link.output_enable_n <= ~i_read;
            o_in_full <= ~syn[5];
            o_out_valid <= syn[4];
            o_rdata <= syn[3:0];
        end
    end
endmodule

/* File: sim/fifo_checker.sv */
`timescale 1ns/1ps
module fifo_checker (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic parallel_load,
    input wire logic transfer_to_stack_n,
    input wire logic transfer_out_parallel,
    input wire logic output_enable_n,
    input wire logic input_full_n,
    input wire logic output_empty_n,
    input wire logic [3:0] parallel_data_out,
    input wire logic [3:0] parallel_data_out_oe_n,
    input wire logic serial_data_out_oe_n
);
    // ----------------------------------------
    // link pin checks
    // ----------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_top_recent;
        $past(transfer_out_parallel, 2) || $past(transfer_out_parallel, 3) || $past(transfer_out_parallel, 4);
    endsequence
    sequence s_oe_steady;
        (i_rst_n && $stable(output_enable_n)) [*6];
    endsequence
    a_reset_flags: assert property (!$past(i_rst_n) |-> input_full_n && !output_empty_n)
        else $error("flags not at initial value after reset");
    a_load_full: assert property ($rose(parallel_load) |-> ##[1:8] !input_full_n)
        else $error("parallel load did not mark input full");
    a_init_after_load: assert property ($rose(input_full_n) |-> !$past(parallel_load))
        else $error("input register cleared while parallel load high");
    a_oe_follows: assert property (s_oe_steady |-> parallel_data_out_oe_n == {4{output_enable_n}})
        else $error("parallel output enable does not follow its control");
    a_empty_needs_top: assert property ($rose(output_empty_n) |-> s_top_recent)
        else $error("output word loaded without transfer out high");
    a_top_low_empty: assert property ($fell(transfer_out_parallel) |-> ##[1:8] !output_empty_n)
        else $error("output flag stayed high after transfer out low");
    a_data_kept: assert property ($fell(output_empty_n) |-> $stable(parallel_data_out) [*3])
        else $error("parallel output changed after extraction");
    a_serial_flag: assert property (!serial_data_out_oe_n |-> output_empty_n)
        else $error("serial output driven with no word held");
    a_full_holds: assert property (!input_full_n && transfer_to_stack_n && $past(transfer_to_stack_n)
        && $past(transfer_to_stack_n, 2) |=> !input_full_n)
        else $error("input register emptied without a stack transfer");
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import fifo_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_write = 1'b0;
    logic [3:0] i_wdata = 4'h0;
    logic i_read = 1'b0;
    logic o_in_full;
    logic o_out_valid;
    logic [3:0] o_rdata;
    logic valid_prev = 1'b0;
    logic [3:0] exp_word;
    logic [3:0] exp_q[$];
    int err_count = 0;
    int cmp_count = 0;
    int n;
    int k;
    bit ok;
    fifo_link_if link();
    always #20 i_core_clk = ~i_core_clk;
    fifo_device u_fifo_device (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .link(link));
    fifo_controller u_fifo_controller (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_write(i_write),
        .i_wdata(i_wdata), .i_read(i_read), .o_in_full(o_in_full), .o_out_valid(o_out_valid),
        .o_rdata(o_rdata), .link(link));
    fifo_checker u_fifo_checker (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .parallel_load(link.parallel_load), .transfer_to_stack_n(link.transfer_to_stack_n),
        .transfer_out_parallel(link.transfer_out_parallel), .output_enable_n(link.output_enable_n),
        .input_full_n(link.input_full_n), .output_empty_n(link.output_empty_n),
        .parallel_data_out(link.parallel_data_out), .parallel_data_out_oe_n(link.parallel_data_out_oe_n),
        .serial_data_out_oe_n(link.serial_data_out_oe_n));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("counts: compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic put(input logic [3:0] d, input int lim, output bit acc);
        n = 0;
        while (o_in_full !== 1'b0 && n < lim) begin
            @(posedge i_core_clk);
            n++;
        end
        acc = (n < lim);
        if (acc) begin
            i_write <= 1'b1;
            i_wdata <= d;
            exp_q.push_back(d);
            @(posedge i_core_clk);
            i_write <= 1'b0;
            repeat (12) @(posedge i_core_clk);
        end
    endtask
    task automatic send(input logic [3:0] d);
        put(d, 400, ok);
        if (!ok) begin
            err_count++;
            finish_test();
        end
    endtask
    task automatic drain();
        i_read <= 1'b1;
        n = 0;
        while (exp_q.size() != 0 && n < 4000) begin
            @(posedge i_core_clk);
            n++;
        end
        if (n >= 4000) begin
            err_count++;
            finish_test();
        end
        repeat (40) @(posedge i_core_clk);
    endtask
    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(posedge i_core_clk) begin
        valid_prev <= o_out_valid;
        if (i_rst_n && o_out_valid === 1'b1 && valid_prev !== 1'b1) begin
            exp_word = (exp_q.size() != 0) ? exp_q.pop_front() : 4'hx;
            check(o_rdata, exp_word);
            if (link.parallel_data_out_oe_n === 4'h0) begin
                check(link.parallel_data_out, exp_word);
            end
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(75));
        repeat (16) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        check({3'h0, link.input_full_n}, 4'h1);
        check({3'h0, link.output_empty_n}, 4'h0);
        $display("test reset_flags done");
        i_read <= 1'b1;
        for (int i = 0; i < 6; i++) send(4'($urandom));
        send(4'h0);
        send(4'hf);
        drain();
        $display("test stream_order done");
        i_read <= 1'b0;
        k = 0;
        ok = 1'b1;
        while (ok && k < 20) begin
            put(4'($urandom), 100, ok);
            k += ok ? 1 : 0;
        end
        check({3'h0, o_in_full}, 4'h1);
        check({3'h0, link.input_full_n}, 4'h0);
        check(4'(k), 4'(STACK_DEPTH + 1));
        check(link.parallel_data_out_oe_n, 4'hf);
        drain();
        $display("test fill_and_drain done");
        i_read <= 1'b0;
        send(4'($urandom));
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        check({3'h0, link.input_full_n}, 4'h1);
        check({3'h0, link.output_empty_n}, 4'h0);
        exp_q.delete();
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        send(4'h5);
        send(4'ha);
        drain();
        $display("test reset_mid_run done");
        finish_test();
    end
endmodule
